//--- HANDOVER_unused_guard.sv
`default_nettype none
`default_nettype wire

//--- iskm_core.sv
`timescale 1ns/1ps
`default_nettype none
module iskm_core import iskm_pkg::*; #(
  parameter int unsigned DEPTH = 4096
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Fetch and configuration
  input wire logic [15:0] instr_in,
  input wire logic [3:0] bsr_in,
  input wire logic ext_set_en_in,
  // Core state
  output logic [7:0] w_out,
  output iskm_flags_t flags_out,
  output iskm_ptrs_t ptr_out,
  output logic discard_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ir_q;
  logic [ADDR_W-1:0] addr_q;
  iskm_state_t state_q, state_d;
  logic [7:0] w_q, w_d;
  iskm_flags_t flags_q, flags_d;
  iskm_ptrs_t ptr_q, ptr_d;
  logic [1:0] ld_sel_q, ld_sel_d;
  logic discard_q;
  logic [7:0] rd_data;
  iskm_wr_t wr;

  wire exec = (state_q == ST_EXEC);
  wire is_inc = exec && (ir_q[15:10] == OP6_INC_SKIP);
  wire is_mov = exec && (ir_q[15:10] == OP6_MOVE);
  wire is_ld = exec && (ir_q[15:8] == OP8_LOAD_PTR) && (ir_q[7:6] == LOAD_PTR_PAD);
  wire dest_file = ir_q[D_BIT];
  wire [1:0] ld_sel = ir_q[5:4];
  wire [7:0] inc_sum = rd_data + BYTE_ONE;
  wire inc_skip = is_inc && (inc_sum != 8'h00);
  wire skip_two = is_two_word(ir_q);
  // Next instruction's operand address, using pointer values about to land
  wire [ADDR_W-1:0] fetch_addr = file_addr(instr_in, bsr_in, ext_set_en_in, ptr_d[ILO_PTR]);

  ////////////////////////////////////////////////////////////////////////////
  iskm_file_ram #(
    .DEPTH(DEPTH)
  ) u_ram (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .rd_addr_in(fetch_addr),
    .wr_in(wr),
    .rd_data_out(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    w_d = w_q;
    flags_d = flags_q;
    ptr_d = ptr_q;
    ld_sel_d = ld_sel_q;
    wr = '0;
    unique case (state_q)
      ST_EXEC: begin
        if (is_inc) begin
          if (dest_file) begin
            wr = '{en: 1'b1, addr: addr_q, data: inc_sum}; // see RULE1
          end else begin
            w_d = inc_sum; // see RULE1
          end
          if (inc_skip) begin
            state_d = ST_SKIP; // see RULE2
          end
        end
        if (is_mov) begin
          if (dest_file) begin
            wr = '{en: 1'b1, addr: addr_q, data: rd_data}; // see RULE9
          end else begin
            w_d = rd_data; // see RULE9
          end
          flags_d.z = (rd_data == 8'h00); // see RULE10 see RULE12
          flags_d.n = rd_data[7]; // see RULE12
        end
        if (is_ld) begin
          ld_sel_d = ld_sel;
          if (ld_sel < NUM_PTRS) begin
            ptr_d[ld_sel][PTR_W-1:8] = ir_q[3:0]; // see RULE7 see RULE8
          end
          state_d = ST_LOAD_LO;
        end
      end
      ST_SKIP: begin
        state_d = skip_two ? ST_SKIP2 : ST_EXEC; // see RULE3
      end
      ST_SKIP2: begin
        state_d = ST_EXEC;
      end
      ST_LOAD_LO: begin
        if (ld_sel_q < NUM_PTRS) begin
          ptr_d[ld_sel_q][7:0] = ir_q[7:0]; // see RULE8
        end
        state_d = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ir_q <= NOP_WORD;
      addr_q <= '0;
      state_q <= ST_EXEC;
      w_q <= W_RESET;
      flags_q <= '0;
      ptr_q <= {NUM_PTRS{PTR_RESET}};
      ld_sel_q <= 2'h0;
      discard_q <= 1'b0;
    end else begin
      ir_q <= instr_in;
      addr_q <= fetch_addr; // see RULE5 see RULE6 see RULE11
      state_q <= state_d;
      w_q <= w_d;
      flags_q <= flags_d; // see RULE4
      ptr_q <= ptr_d;
      ld_sel_q <= ld_sel_d;
      discard_q <= (state_d == ST_SKIP) || (state_d == ST_SKIP2);
    end
  end

  assign w_out = w_q;
  assign flags_out = flags_q;
  assign ptr_out = ptr_q;
  assign discard_out = discard_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_inc_dest;
    is_inc |-> (dest_file ? (wr.en && wr.addr == addr_q && wr.data == inc_sum)
                          : !wr.en) ##1
      (w_q == ($past(dest_file) ? $past(w_q) : $past(inc_sum)));
  endproperty
  a_inc_dest: assert property (p_inc_dest) else $error("increment result misplaced"); // see RULE1

  property p_skip_one;
    (is_inc && rd_data != 8'hFF) |=> (state_q == ST_SKIP) && discard_out && !wr.en;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("non-zero result did not skip"); // see RULE2

  property p_no_skip;
    (is_inc && rd_data == 8'hFF) |=> exec;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("zero result skipped"); // see RULE2

  property p_skip_two;
    (state_q == ST_SKIP && skip_two) |=> (state_q == ST_SKIP2 && discard_out) ##1 exec;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip wrong length"); // see RULE3

  property p_flags_kept;
    (is_inc || is_ld) |=> $stable(flags_q);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed"); // see RULE4

  property p_bank;
    instr_in[A_BIT] |=> addr_q == {$past(bsr_in), $past(instr_in[7:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong"); // see RULE5

  property p_indexed;
    (!instr_in[A_BIT] && ext_set_en_in && instr_in[7:0] <= ILO_MAX_F) |->
      fetch_addr == ptr_d[ILO_PTR] + {4'h0, instr_in[7:0]};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong"); // see RULE6

  property p_load_ptr;
    (is_ld && ld_sel < NUM_PTRS) |=> (state_q == ST_LOAD_LO &&
      ptr_q[ld_sel_q][PTR_W-1:8] == $past(ir_q[3:0])) ##1
      (exec && ptr_q[ld_sel_q][7:0] == $past(ir_q[7:0]));
  endproperty
  a_load_ptr: assert property (p_load_ptr) else $error("pointer load wrong"); // see RULE7 see RULE8

  property p_move;
    (is_mov && !dest_file) |=> w_q == $past(rd_data) && exec;
  endproperty
  a_move: assert property (p_move) else $error("move to W wrong"); // see RULE9 see RULE11

  property p_move_flags;
    is_mov |=> flags_q.z == ($past(rd_data) == 8'h00) && flags_q.n == $past(rd_data[7]);
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move flags wrong"); // see RULE10 see RULE12

  property p_move_file;
    (is_mov && dest_file) |-> (wr.en && wr.addr == addr_q && wr.data == rd_data) ##1
      (w_q == $past(w_q));
  endproperty
  a_move_file: assert property (p_move_file) else $error("move to file wrong"); // see RULE9

  property p_access;
    (!instr_in[A_BIT] && !ext_set_en_in) |=>
      addr_q[11:8] == (($past(instr_in[7:0]) <= ILO_MAX_F) ? 4'h0 : ACCESS_HI_BANK) &&
      addr_q[7:0] == $past(instr_in[7:0]);
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong"); // see RULE5

  property p_sel_none;
    (is_ld && ld_sel == 2'h3) |=> (state_q == ST_LOAD_LO && $stable(ptr_q)) ##1
      (exec && $stable(ptr_q));
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("select 3 wrote"); // see RULE7

  property p_skip_quiet;
    (state_q == ST_SKIP || state_q == ST_SKIP2) |-> !wr.en ##1
      ($stable(w_q) && $stable(flags_q) && $stable(ptr_q));
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("skip had effect"); // see RULE2

  property p_cv_skip2;
    inc_skip ##1 (state_q == ST_SKIP && skip_two);
  endproperty
  c_skip2: cover property (p_cv_skip2);
  c_load: cover property (is_ld ##1 state_q == ST_LOAD_LO);
  c_move_zero: cover property (is_mov && rd_data == 8'h00);
  c_no_skip: cover property (is_inc && rd_data == 8'hFF);
  c_sel3: cover property (is_ld && ld_sel == 2'h3);

endmodule // iskm_core
`default_nettype wire

//--- iskm_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module iskm_core_test import iskm_pkg::*;;
  logic clk_in;
  logic nrst_in;
  logic [15:0] instr_in;
  logic [3:0] bsr_in;
  logic ext_set_en_in;
  logic [7:0] w_out;
  iskm_flags_t flags_out;
  iskm_ptrs_t ptr_out;
  logic discard_out;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  iskm_core dut_u (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .instr_in(instr_in),
    .bsr_in(bsr_in),
    .ext_set_en_in(ext_set_en_in),
    .w_out(w_out),
    .flags_out(flags_out),
    .ptr_out(ptr_out),
    .discard_out(discard_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk_val(input string nm, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic run(input logic [15:0] word);
    @(posedge clk_in);
    instr_in <= word;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Move to W and check value and both flags two edges later
  task automatic mv(input logic [7:0] f, input logic a, input logic ext, input logic [7:0] e);
    @(posedge clk_in);
    ext_set_en_in <= ext;
    instr_in <= {OP6_MOVE, 1'b0, a, f};
    run(NOP_WORD);
    run(NOP_WORD);
    #1;
    chk_val("w", {4'h0, e}, {4'h0, w_out});
    chk_bit("n", e[7], flags_out.n);
    chk_bit("z", e == 8'h00, flags_out.z);
  endtask

  // Increment-skip followed by two words; discard pattern over two cycles
  task automatic inc(input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] w3,
                     input logic e1, input logic e2);
    run(w1);
    run(w2);
    run(w3);
    #1;
    chk_bit("discard first", e1, discard_out);
    run(NOP_WORD);
    #1;
    chk_bit("discard second", e2, discard_out);
    run(NOP_WORD);
    run(NOP_WORD);
    #1;
  endtask

  task automatic ptr_load(input int i, input logic [11:0] k);
    iskm_flags_t fl;
    fl = flags_out;
    run({OP8_LOAD_PTR, LOAD_PTR_PAD, i[1:0], k[11:8]});
    run({8'hF0, k[7:0]});
    run(NOP_WORD);
    #1;
    chk_val("ptr high", {k[11:8], 8'h00}, ptr_out[i]);
    run(NOP_WORD);
    #1;
    chk_val("ptr full", k, ptr_out[i]);
    chk_val("flags kept", {10'h000, fl}, {10'h000, flags_out});
  endtask

  // Pointer select 3: nothing written, second word still swallowed
  task automatic ptr_sel3();
    iskm_ptrs_t p;
    logic [7:0] w;
    p = ptr_out;
    w = w_out;
    run({OP8_LOAD_PTR, LOAD_PTR_PAD, 2'b11, 4'h5});
    run({OP6_MOVE, 2'b00, 8'h20});
    run(NOP_WORD);
    run(NOP_WORD);
    #1;
    chk_val("ptr0 sel3", p[0], ptr_out[0]);
    chk_val("ptr1 sel3", p[1], ptr_out[1]);
    chk_val("ptr2 sel3", p[2], ptr_out[2]);
    chk_val("w sel3", {4'h0, w}, {4'h0, w_out});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    nrst_in = 1'b0;
    instr_in = NOP_WORD;
    bsr_in = 4'h3;
    ext_set_en_in = 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1;
    chk_val("w reset", {4'h0, W_RESET}, {4'h0, w_out});
    chk_val("ptr2 reset", PTR_RESET, ptr_out[2]);
    chk_bit("discard reset", 1'b0, discard_out);
    dut_u.u_ram.mem_q[12'h310] = 8'h85;
    dut_u.u_ram.mem_q[12'h311] = 8'h00;
    dut_u.u_ram.mem_q[12'h312] = 8'h05;
    dut_u.u_ram.mem_q[12'h313] = 8'hFF;
    dut_u.u_ram.mem_q[12'h3FF] = 8'h7E;
    dut_u.u_ram.mem_q[12'h020] = 8'h11;
    dut_u.u_ram.mem_q[12'hF80] = 8'hC3;
    dut_u.u_ram.mem_q[12'h3BB] = 8'h5A;
    mv(8'h11, 1'b1, 1'b0, 8'h00);
    mv(8'hFF, 1'b1, 1'b0, 8'h7E);
    mv(8'h10, 1'b1, 1'b0, 8'h85);
    // Zero result: no skip, W gets 00, flags untouched
    inc({OP6_INC_SKIP, 2'b01, 8'h13}, NOP_WORD, NOP_WORD, 1'b0, 1'b0);
    chk_val("w inc", 12'h000, {4'h0, w_out});
    chk_bit("n kept", 1'b1, flags_out.n);
    chk_bit("z kept", 1'b0, flags_out.z);
    // Non-zero result into file; the following move must be dropped
    inc({OP6_INC_SKIP, 2'b11, 8'h12}, {OP6_MOVE, 2'b01, 8'h10}, NOP_WORD, 1'b1, 1'b0);
    chk_val("w after skip", 12'h000, {4'h0, w_out});
    mv(8'h12, 1'b1, 1'b0, 8'h06);
    // Skipped pointer-load: both words dropped
    inc({OP6_INC_SKIP, 2'b11, 8'h12}, {OP8_LOAD_PTR, 8'h23}, 16'hF0AB, 1'b1, 1'b1);
    chk_val("ptr2 after skip", PTR_RESET, ptr_out[2]);
    mv(8'h12, 1'b1, 1'b0, 8'h07);
    mv(8'h11, 1'b1, 1'b0, 8'h00);
    ptr_load(0, 12'hF01);
    ptr_load(1, 12'h0FF);
    ptr_load(2, 12'h3AB);
    chk_val("ptr0 kept", 12'hF01, ptr_out[0]);
    ptr_sel3();
    mv(8'h20, 1'b0, 1'b0, 8'h11);
    mv(8'h80, 1'b0, 1'b0, 8'hC3);
    mv(8'h10, 1'b0, 1'b1, 8'h5A);
    mv(8'h80, 1'b0, 1'b1, 8'hC3);
    close_out();
  end
endmodule // iskm_core_test
`default_nettype wire

//--- iskm_file_ram.sv
`timescale 1ns/1ps
`default_nettype none
module iskm_file_ram import iskm_pkg::*; #(
  parameter int unsigned DEPTH = 4096
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Ports
  input wire logic [ADDR_W-1:0] rd_addr_in,
  input wire iskm_wr_t wr_in,
  output logic [7:0] rd_data_out
);

  logic [7:0] mem_q [DEPTH];

  // Plain always so a bench may preload the array directly
  always @(posedge clk_in) begin
    if (wr_in.en) begin
      mem_q[wr_in.addr] <= wr_in.data;
    end
  end

  // Write-first so a back-to-back read sees the byte just written
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rd_data_out <= 8'h00;
    end else if (wr_in.en && wr_in.addr == rd_addr_in) begin
      rd_data_out <= wr_in.data;
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule // iskm_file_ram
`default_nettype wire

//--- iskm_pkg.sv
// Notes on behaviour
// RULE1 - Increment-skip adds one; result to W when d clear, else to file.
// RULE2 - Non-zero result discards prefetched word, runs a no-op cycle instead.
// RULE3 - Skipped two-word instruction: both words become no-ops, three cycles total.
// RULE4 - Increment-skip and pointer-load leave every status flag unchanged.
// RULE5 - a clear selects access bank; a set selects bank from bank select.
// RULE6 - a clear, extended set on, f at most 95: indexed literal offset.
// RULE7 - Pointer-load puts a 12-bit literal into pointer 0, 1 or 2.
// RULE8 - Pointer-load spans two words: upper four bits first cycle, low byte second.
// RULE9 - Move-file copies file to W when d clear, else back to file.
// RULE10 - Move-file updates N and Z from the moved value only.
// RULE11 - Move-file reaches the whole selected bank and completes in one cycle.
// RULE12 - Z set when moved byte is zero; N takes bit 7.
package iskm_pkg;

  localparam logic [5:0] OP6_INC_SKIP = 6'h12;
  localparam logic [5:0] OP6_MOVE = 6'h14;
  localparam logic [7:0] OP8_LOAD_PTR = 8'hEE;
  localparam logic [1:0] LOAD_PTR_PAD = 2'h0;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  localparam logic [7:0] ILO_MAX_F = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam int NUM_PTRS = 3;
  localparam int PTR_W = 12;
  localparam int ADDR_W = 12;
  localparam int ILO_PTR = 2;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_SKIP = 2'b01,
    ST_SKIP2 = 2'b10,
    ST_LOAD_LO = 2'b11
  } iskm_state_t;

  typedef struct packed {
    logic n;
    logic z;
  } iskm_flags_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } iskm_wr_t;

  typedef logic [NUM_PTRS-1:0][PTR_W-1:0] iskm_ptrs_t;

  // Words that carry a second program word behind them
  function automatic logic is_two_word(input logic [15:0] word);
    return (word[15:12] == 4'hC) || (word[15:9] == 7'h76) || (word[15:8] == 8'hEE) ||
           (word[15:8] == 8'hEF);
  endfunction

  // Effective data address of a file-register instruction word
  function automatic logic [ADDR_W-1:0] file_addr(input logic [15:0] word,
                                                   input logic [3:0] bank,
                                                   input logic ext_en,
                                                   input logic [PTR_W-1:0] base);
    logic [7:0] f;
    f = word[7:0];
    if (word[A_BIT]) begin
      return {bank, f};
    end else if (ext_en && f <= ILO_MAX_F) begin
      return base + {4'h0, f};
    end else if (f <= ILO_MAX_F) begin
      return {4'h0, f};
    end
    return {ACCESS_HI_BANK, f};
  endfunction

endpackage
